// ==== src/hcam_monitor.sv ====
// Summary of operation
// - Output on: current below burnout threshold alarms
// - Output off: current above relay threshold alarms
// - Burnout threshold 0.1 to 49.9 A
// - Relay threshold 0.1 to 49.9 A
// - Burnout check needs 100 ms on
// - Fast periods reduce on minimum to 30 ms
// - Relay check needs 100 ms off
// - Fast periods reduce off minimum to 35 ms
// - One or two current inputs checked
`timescale 1ns/1ns
`default_nettype none
module hcam_monitor
  import hcam_pkg::*;
#(
  parameter int unsigned NUM_CT = 2,
  parameter int unsigned ON_MIN_CYC = HCAM_ON_MIN_CYC,
  parameter int unsigned OFF_MIN_CYC = HCAM_OFF_MIN_CYC,
  parameter int unsigned ON_FAST_CYC = HCAM_ON_FAST_CYC,
  parameter int unsigned OFF_FAST_CYC = HCAM_OFF_FAST_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_ctrl_out,
  input wire logic i_fast_period,
  input wire logic [NUM_CT*9-1:0] i_ct_current,
  input wire logic [8:0] i_burn_thr,
  input wire logic [8:0] i_ssr_thr,
  output logic o_burn_alarm,
  output logic o_ssr_alarm
);
  localparam logic [23:0] ON_LONG = 24'(ON_MIN_CYC);
  localparam logic [23:0] OFF_LONG = 24'(OFF_MIN_CYC);
  localparam logic [23:0] ON_SHORT = 24'(ON_FAST_CYC);
  localparam logic [23:0] OFF_SHORT = 24'(OFF_FAST_CYC);

  hcam_thr_if thr ();

  hcam_thr_clamp u_clamp (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_burn_thr(i_burn_thr),
    .i_ssr_thr(i_ssr_thr),
    .thr(thr)
  );

  // Two-stage synchronisers for pin-level inputs
  logic ctrl_s1_ff;
  logic ctrl_ff;
  logic fast_s1_ff;
  logic fast_ff;
  logic ctrl_d_ff;
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ctrl_s1_ff <= 1'b0;
      ctrl_ff <= 1'b0;
      ctrl_d_ff <= 1'b0;
      fast_s1_ff <= 1'b0;
      fast_ff <= 1'b0;
    end else begin
      ctrl_s1_ff <= i_ctrl_out;
      ctrl_ff <= ctrl_s1_ff;
      ctrl_d_ff <= ctrl_ff;
      fast_s1_ff <= i_fast_period;
      fast_ff <= fast_s1_ff;
    end
  end

  logic [NUM_CT*9-1:0] ct_s1_ff;
  logic [NUM_CT*9-1:0] ct_ff;
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ct_s1_ff <= '0;
      ct_ff <= '0;
    end else begin
      ct_s1_ff <= i_ct_current;
      ct_ff <= ct_s1_ff;
    end
  end

  // Interval counter restarts at each edge of the control output
  logic [23:0] run_ff;
  logic [23:0] nxt_run;
  logic same_level;
  assign same_level = (ctrl_ff == ctrl_d_ff);
  assign nxt_run = same_level && (run_ff != 24'hFFFFFF) ?
    run_ff + 24'h000001 : 24'h000001;
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      run_ff <= HCAM_CNT_RST;
    end else begin
      run_ff <= nxt_run;
    end
  end

  logic [23:0] on_need;
  logic [23:0] off_need;
  assign on_need = fast_ff ? ON_SHORT : ON_LONG;
  assign off_need = fast_ff ? OFF_SHORT : OFF_LONG;

  logic on_ok;
  logic off_ok;
  assign on_ok = ctrl_ff && same_level && (run_ff >= on_need);
  assign off_ok = !ctrl_ff && same_level && (run_ff >= off_need);

  logic [NUM_CT-1:0] low_v;
  logic [NUM_CT-1:0] high_v;
  for (genvar g = 0; g < NUM_CT; g++) begin : g_ct
    assign low_v[g] = ct_ff[g*9 +: 9] < thr.burn_thr;
    assign high_v[g] = ct_ff[g*9 +: 9] > thr.ssr_thr;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_burn_alarm <= 1'b0;
    end else if (on_ok) begin
      o_burn_alarm <= |low_v;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_ssr_alarm <= 1'b0;
    end else if (off_ok) begin
      o_ssr_alarm <= |high_v;
    end
  end

  property p_burn_hold;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      !on_ok |=> o_burn_alarm == $past(o_burn_alarm);
  endproperty
  a_burn_hold: assert property (p_burn_hold)
    else $error("burn alarm changed while unqualified");

  property p_ssr_hold;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      !off_ok |=> $stable(o_ssr_alarm);
  endproperty
  a_ssr_hold: assert property (p_ssr_hold)
    else $error("relay alarm changed while unqualified");

  property p_burn_set;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      on_ok && (|low_v) |=> o_burn_alarm;
  endproperty
  a_burn_set: assert property (p_burn_set)
    else $error("burn alarm not raised on low current");

  property p_ssr_set;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      off_ok && (|high_v) |=> o_ssr_alarm;
  endproperty
  a_ssr_set: assert property (p_ssr_set)
    else $error("relay alarm not raised on high current");

  // Alarm moved with no reset in the cycle before
  sequence s_burn_moved;
    !$past(i_sys_rst) && $changed(o_burn_alarm);
  endsequence

  sequence s_ssr_moved;
    !$past(i_sys_rst) && $changed(o_ssr_alarm);
  endsequence

  property p_on_slow;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      s_burn_moved ##0 !$past(fast_ff) |->
      $past(ctrl_ff) && ($past(run_ff) >= ON_LONG);
  endproperty
  a_on_slow: assert property (p_on_slow)
    else $error("burn check before long on minimum");

  property p_on_fast;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      s_burn_moved ##0 $past(fast_ff) |->
      $past(ctrl_ff) && ($past(run_ff) >= ON_SHORT);
  endproperty
  a_on_fast: assert property (p_on_fast)
    else $error("burn check before short on minimum");

  property p_off_slow;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      s_ssr_moved ##0 !$past(fast_ff) |->
      !$past(ctrl_ff) && ($past(run_ff) >= OFF_LONG);
  endproperty
  a_off_slow: assert property (p_off_slow)
    else $error("relay check before long off minimum");

  property p_off_fast;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      s_ssr_moved ##0 $past(fast_ff) |->
      !$past(ctrl_ff) && ($past(run_ff) >= OFF_SHORT);
  endproperty
  a_off_fast: assert property (p_off_fast)
    else $error("relay check before short off minimum");

  property p_thr_range;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      ##1 thr.burn_thr >= HCAM_THR_MIN && thr.burn_thr <= HCAM_THR_MAX
      && thr.ssr_thr >= HCAM_THR_MIN && thr.ssr_thr <= HCAM_THR_MAX;
  endproperty
  a_thr_range: assert property (p_thr_range)
    else $error("threshold out of range");

  property p_ct_any;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      on_ok && (|low_v) && !(low_v[0]) |=> o_burn_alarm;
  endproperty
  a_ct_any: assert property (p_ct_any)
    else $error("second input not checked");
endmodule : hcam_monitor
`default_nettype wire

// ==== src/hcam_pkg.sv ====
package hcam_pkg;
  // Threshold counts in 0.1 A steps
  localparam int unsigned HCAM_THR_W = 9;
  localparam logic [8:0] HCAM_THR_MIN = 9'h001;
  localparam logic [8:0] HCAM_THR_MAX = 9'h1F3;
  localparam logic [8:0] HCAM_THR_RST = 9'h001;
  // Qualifying times in microseconds
  localparam int unsigned HCAM_CLK_MHZ = 125;
  localparam int unsigned HCAM_ON_MIN_US = 100000;
  localparam int unsigned HCAM_OFF_MIN_US = 100000;
  localparam int unsigned HCAM_ON_FAST_US = 30000;
  localparam int unsigned HCAM_OFF_FAST_US = 35000;
  localparam int unsigned HCAM_ON_MIN_CYC = HCAM_ON_MIN_US * HCAM_CLK_MHZ;
  localparam int unsigned HCAM_OFF_MIN_CYC = HCAM_OFF_MIN_US * HCAM_CLK_MHZ;
  localparam int unsigned HCAM_ON_FAST_CYC = HCAM_ON_FAST_US * HCAM_CLK_MHZ;
  localparam int unsigned HCAM_OFF_FAST_CYC =
    HCAM_OFF_FAST_US * HCAM_CLK_MHZ;
  localparam int unsigned HCAM_CNT_W = 24;
  localparam logic [23:0] HCAM_CNT_RST = 24'h000000;
endpackage : hcam_pkg

// ==== src/hcam_thr_clamp.sv ====
`timescale 1ns/1ns
`default_nettype none
module hcam_thr_clamp
  import hcam_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [8:0] i_burn_thr,
  input wire logic [8:0] i_ssr_thr,
  hcam_thr_if.src thr
);
  function automatic logic [8:0] clamp(input logic [8:0] v);
    if (v < HCAM_THR_MIN) begin
      return HCAM_THR_MIN;
    end
    if (v > HCAM_THR_MAX) begin
      return HCAM_THR_MAX;
    end
    return v;
  endfunction : clamp

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      thr.burn_thr <= HCAM_THR_RST;
    end else begin
      thr.burn_thr <= clamp(i_burn_thr);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      thr.ssr_thr <= HCAM_THR_RST;
    end else begin
      thr.ssr_thr <= clamp(i_ssr_thr);
    end
  end
endmodule : hcam_thr_clamp
`default_nettype wire

// ==== src/hcam_thr_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface hcam_thr_if;
  logic [8:0] burn_thr;
  logic [8:0] ssr_thr;
  modport src (output burn_thr, output ssr_thr);
  modport dst (input burn_thr, input ssr_thr);
endinterface : hcam_thr_if
`default_nettype wire

// ==== tb/hcam_ct_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module hcam_ct_model #(
  parameter int unsigned NUM_CT = 2
) (
  input wire logic i_heat_on,
  input wire logic [NUM_CT*9-1:0] i_on_amps,
  input wire logic [NUM_CT*9-1:0] i_off_amps,
  output logic [NUM_CT*9-1:0] o_ct_current
);
  // Off reading stands for a shorted relay leaking load current
  assign o_ct_current = i_heat_on ? i_on_amps : i_off_amps;
endmodule : hcam_ct_model
`default_nettype wire

// ==== tb/heater_current_alarm_monitor_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module heater_current_alarm_monitor_tb_top;
  import hcam_pkg::*;
  localparam int unsigned ON_C = 20;
  localparam int unsigned OFF_C = 20;
  localparam int unsigned ON_F = 6;
  localparam int unsigned OFF_F = 7;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ctrl = 1'b0;
  logic fast = 1'b0;
  logic [17:0] on_a = 18'h00000;
  logic [17:0] off_a = 18'h00000;
  logic [8:0] b_thr = 9'h001;
  logic [8:0] s_thr = 9'h001;
  logic [17:0] ct;
  logic burn;
  logic ssr;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  hcam_ct_model #(.NUM_CT(2)) u_ct (.i_heat_on(ctrl), .i_on_amps(on_a),
    .i_off_amps(off_a), .o_ct_current(ct));
  hcam_monitor #(.NUM_CT(2), .ON_MIN_CYC(ON_C), .OFF_MIN_CYC(OFF_C),
    .ON_FAST_CYC(ON_F), .OFF_FAST_CYC(OFF_F)) uut (.i_core_clk(clk),
    .i_sys_rst(rst), .i_ctrl_out(ctrl), .i_fast_period(fast),
    .i_ct_current(ct), .i_burn_thr(b_thr), .i_ssr_thr(s_thr),
    .o_burn_alarm(burn), .o_ssr_alarm(ssr));
  task automatic chk(input logic seen, input logic exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: alarm %b, expected %b", $time, seen, exp);
    end
  endtask : chk
  task automatic hold(input logic on, input int unsigned n);
    @(posedge clk);
    ctrl <= on;
    repeat (n) @(posedge clk);
    #1;
  endtask : hold
  task automatic t_burn;
    @(posedge clk);
    b_thr <= 9'h064;
    on_a <= {9'h096, 9'h032};
    hold(1'b1, 10);
    chk(burn, 1'b0);
    hold(1'b1, 16);
    chk(burn, 1'b1);
    hold(1'b0, OFF_C + 6);
    chk(burn, 1'b1);
    chk(ssr, 1'b0);
  endtask : t_burn
  task automatic t_ssr;
    @(posedge clk);
    s_thr <= 9'h0C8;
    // Leak applied only once the output is on
    ctrl <= 1'b1;
    off_a <= {9'h12C, 9'h000};
    hold(1'b1, 3);
    hold(1'b0, 10);
    chk(ssr, 1'b0);
    chk(burn, 1'b1);
    hold(1'b0, 16);
    chk(ssr, 1'b1);
    @(posedge clk);
    on_a <= {9'h096, 9'h096};
    hold(1'b1, ON_C + 6);
    chk(burn, 1'b0);
    chk(ssr, 1'b1);
  endtask : t_ssr
  task automatic t_fast;
    @(posedge clk);
    fast <= 1'b1;
    // New load current must not reach a qualified on interval
    ctrl <= 1'b0;
    on_a <= {9'h096, 9'h032};
    off_a <= 18'h00000;
    hold(1'b0, 4);
    chk(ssr, 1'b1);
    chk(burn, 1'b0);
    hold(1'b1, ON_F + 6);
    chk(burn, 1'b1);
    hold(1'b0, OFF_F + 6);
    chk(ssr, 1'b0);
  endtask : t_fast
  task automatic t_clamp;
    @(posedge clk);
    b_thr <= 9'h1FF;
    s_thr <= 9'h000;
    on_a <= {9'h1F3, 9'h1F3};
    off_a <= {9'h001, 9'h001};
    hold(1'b1, ON_F + 6);
    chk(burn, 1'b0);
    hold(1'b0, OFF_F + 6);
    chk(ssr, 1'b0);
    @(posedge clk);
    b_thr <= 9'h000;
    on_a <= 18'h00000;
    hold(1'b1, ON_F + 6);
    chk(burn, 1'b1);
  endtask : t_clamp
  // burnout seen on second input only
  task automatic t_ct1;
    @(posedge clk);
    ctrl <= 1'b0;
    b_thr <= 9'h064;
    on_a <= {9'h096, 9'h096};
    hold(1'b1, ON_F + 6);
    chk(burn, 1'b0);
    @(posedge clk);
    ctrl <= 1'b0;
    on_a <= {9'h032, 9'h096};
    hold(1'b1, ON_F + 6);
    chk(burn, 1'b1);
  endtask : t_ct1
  task automatic finish_test;
    $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(burn, 1'b0);
    chk(ssr, 1'b0);
    t_burn();
    t_ssr();
    t_fast();
    t_clamp();
    t_ct1();
    finish_test();
  end
endmodule : heater_current_alarm_monitor_tb_top
`default_nettype wire
